// [hw/ogc_core.sv]
`timescale 1ns/1ps
`default_nettype none
`include "ogc_map.svh"

module ogc_core #(
    parameter int AVG_NUM = `OGC_AVG_NUM
) (
    input  wire logic        clock,
    input  wire logic        arst_n,
    input  wire logic        cs_n,
    input  wire logic        conv_start,
    input  wire logic        filter_valid,
    input  wire logic [23:0] filter_data,
    input  wire logic        internal_offset_cal_cmd,
    input  wire logic        system_offset_cal_cmd,
    input  wire logic        full_scale_cal_cmd,
    input  wire logic        reg_wr,
    input  wire logic [7:0]  reg_addr,
    input  wire logic [7:0]  reg_wdata,
    output logic      [7:0]  reg_rdata,
    output logic      [23:0] result_data,
    output logic             result_valid,
    output logic             data_ready_n,
    output logic             inputs_shorted,
    output logic             cal_busy
);

    localparam int LG = $clog2(AVG_NUM);

    // The accumulator in the state record is sized for at most 16 samples.
    if (AVG_NUM < 2 || AVG_NUM > 16 || (1 << LG) != AVG_NUM) begin : g_chk
        $error("AVG_NUM must be a power of two from 2 to 16.");
    end

    ogc_pkg::ogc_regs_t r;
    ogc_pkg::ogc_regs_t next_r;

    // ------------------------------------------------------------------
    // Correction arithmetic
    // ------------------------------------------------------------------
    logic signed [24:0] diff;
    logic signed [49:0] prod;
    logic signed [27:0] shr;
    logic        [23:0] corr;

    // Difference and product are kept wide so nothing wraps before the
    // clip; only the final value is narrowed.
    always_comb begin
        diff = $signed({r.ofs[23], r.ofs}) * -25'sd1
             + $signed({filter_data[23], filter_data});
        prod = diff * $signed({1'b0, r.gain});
        shr  = 28'(prod >>> `OGC_UNITY_SHIFT);
        if (shr > `OGC_SAT_HI) begin
            corr = `OGC_POS_CLIP;
        end else if (shr < `OGC_SAT_LO) begin
            corr = `OGC_NEG_CLIP;
        end else begin
            corr = shr[23:0];
        end
    end

    // ------------------------------------------------------------------
    // Averaging and divider helpers
    // ------------------------------------------------------------------
    logic signed [28:0] sample;
    logic signed [28:0] acc_new;
    logic signed [28:0] avg;
    logic        [24:0] trial;
    logic               ge;
    logic        [45:0] quo_new;
    logic               cancel;

    // Full-scale averaging works on offset-corrected samples, so the
    // offset found earlier is honoured by the gain word.
    always_comb begin
        if (r.kind == ogc_pkg::OGC_K_GAIN) begin
            sample = 29'(diff);
        end else begin
            sample = 29'($signed(filter_data));
        end
        acc_new = r.acc + sample;
        avg     = acc_new >>> LG;
        trial   = {r.rem[23:0], r.quo[45]};
        ge      = trial >= {1'b0, r.den};
        quo_new = {r.quo[44:0], ge};
        cancel  = r.cs_sync && (r.st != ogc_pkg::OGC_IDLE);
    end

    // ------------------------------------------------------------------
    // Next-state logic
    // ------------------------------------------------------------------
    // Calibration results are assigned after register writes so that a
    // hardware update wins over a write landing in the same cycle.
    always_comb begin
        next_r              = r;
        next_r.cs_meta      = cs_n;
        next_r.cs_sync      = r.cs_meta;
        next_r.result_valid = 1'b0;
        if (conv_start) begin
            next_r.data_ready_n_n = 1'b1;
        end
        unique case (reg_addr)
            `OGC_ADDR_OFS_LO:   next_r.rdata = r.ofs[7:0];
            `OGC_ADDR_OFS_MID:  next_r.rdata = r.ofs[15:8];
            `OGC_ADDR_OFS_HI:   next_r.rdata = r.ofs[23:16];
            `OGC_ADDR_GAIN_LO:  next_r.rdata = r.gain[7:0];
            `OGC_ADDR_GAIN_MID: next_r.rdata = r.gain[15:8];
            `OGC_ADDR_GAIN_HI:  next_r.rdata = r.gain[23:16];
            default:            next_r.rdata = 8'h00;
        endcase
        if (reg_wr) begin
            unique case (reg_addr)
                `OGC_ADDR_OFS_LO:   next_r.ofs[7:0]    = reg_wdata;
                `OGC_ADDR_OFS_MID:  next_r.ofs[15:8]   = reg_wdata;
                `OGC_ADDR_OFS_HI:   next_r.ofs[23:16]  = reg_wdata;
                `OGC_ADDR_GAIN_LO:  next_r.gain[7:0]   = reg_wdata;
                `OGC_ADDR_GAIN_MID: next_r.gain[15:8]  = reg_wdata;
                `OGC_ADDR_GAIN_HI:  next_r.gain[23:16] = reg_wdata;
                default: ;
            endcase
        end
        unique case (r.st)
            ogc_pkg::OGC_IDLE: begin
                // Plain conversions pass the correction path.
                if (filter_valid) begin
                    next_r.result       = corr;
                    next_r.result_valid = 1'b1;
                    next_r.data_ready_n_n       = 1'b0;
                end
                if (!r.cs_sync && (internal_offset_cal_cmd ||
                    system_offset_cal_cmd || full_scale_cal_cmd)) begin
                    next_r.st      = ogc_pkg::OGC_AVG;
                    next_r.acc     = '0;
                    next_r.cnt     = '0;
                    next_r.data_ready_n_n  = 1'b1;
                    next_r.shorted = internal_offset_cal_cmd;
                    if (internal_offset_cal_cmd) begin
                        next_r.kind = ogc_pkg::OGC_K_INT;
                    end else if (system_offset_cal_cmd) begin
                        next_r.kind = ogc_pkg::OGC_K_SYS;
                    end else begin
                        next_r.kind = ogc_pkg::OGC_K_GAIN;
                    end
                end
            end
            ogc_pkg::OGC_AVG: begin
                // Duration scales with the conversion period times count.
                if (filter_valid) begin
                    next_r.acc = acc_new;
                    next_r.cnt = r.cnt + 5'd1;
                    if (r.cnt == 5'(AVG_NUM - 1)) begin
                        if (r.kind != ogc_pkg::OGC_K_GAIN) begin
                            next_r.ofs     = avg[23:0];
                            next_r.shorted = 1'b0;
                            next_r.st      = ogc_pkg::OGC_FINAL;
                        end else if (avg <= 29'sd0) begin
                            // No usable signal: take the largest gain.
                            next_r.gain = `OGC_GAIN_MAX;
                            next_r.st   = ogc_pkg::OGC_FINAL;
                        end else begin
                            next_r.den   = avg[23:0];
                            next_r.rem   = '0;
                            next_r.quo   = {`OGC_FS_CODE,
                                            {`OGC_UNITY_SHIFT{1'b0}}};
                            next_r.steps = '0;
                            next_r.st    = ogc_pkg::OGC_DIV;
                        end
                    end
                end
            end
            ogc_pkg::OGC_DIV: begin
                // One quotient bit per clock; conversions meanwhile are
                // dropped, and the first one after the 46 steps ends calibration.
                next_r.rem   = ge ? trial - {1'b0, r.den} : trial;
                next_r.quo   = quo_new;
                next_r.steps = r.steps + 6'd1;
                if (r.steps == `OGC_DIV_LAST) begin
                    next_r.gain = (|quo_new[45:24]) ? `OGC_GAIN_MAX
                                                    : quo_new[23:0];
                    next_r.st   = ogc_pkg::OGC_FINAL;
                end
            end
            ogc_pkg::OGC_FINAL: begin
                if (filter_valid) begin
                    next_r.result       = corr;
                    next_r.result_valid = 1'b1;
                    next_r.data_ready_n_n       = 1'b0;
                    next_r.st           = ogc_pkg::OGC_IDLE;
                end
            end
        endcase
        // Chip select raised mid-calibration abandons it once it has passed the two-flop synchronizer.
        if (cancel) begin
            next_r.st      = ogc_pkg::OGC_IDLE;
            next_r.shorted = 1'b0;
        end
    end

    // ------------------------------------------------------------------
    // State register
    // ------------------------------------------------------------------
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            r         <= '0;
            r.ofs     <= `OGC_OFS_RESET;
            r.gain    <= `OGC_GAIN_RESET;
            r.data_ready_n_n  <= 1'b1;
            r.cs_meta <= 1'b1;
            r.cs_sync <= 1'b1;
        end else begin
            r <= next_r;
        end
    end

    assign reg_rdata      = r.rdata;
    assign result_data    = r.result;
    assign result_valid   = r.result_valid;
    assign data_ready_n   = r.data_ready_n_n;
    assign inputs_shorted = r.shorted;
    assign cal_busy       = r.st != ogc_pkg::OGC_IDLE;

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    default clocking cb @(posedge clock); endclocking
    default disable iff (!arst_n);

    AST_NEUTRAL: assert property (
        (r.st == ogc_pkg::OGC_IDLE) && filter_valid
        && r.ofs == 24'h000000 && r.gain == `OGC_GAIN_RESET
        |=> result_valid && result_data == $past(filter_data))
        else $error("Neutral words altered the result.");

    AST_CLIP: assert property (
        filter_valid && (r.st == ogc_pkg::OGC_IDLE)
        && r.gain == `OGC_GAIN_MAX && filter_data == `OGC_POS_CLIP
        && r.ofs == `OGC_NEG_CLIP
        |=> result_data == `OGC_POS_CLIP)
        else $error("Overflowing result was not clipped high.");

    AST_OFS_WR: assert property (
        reg_wr && reg_addr == `OGC_ADDR_OFS_HI && !cal_busy
        |=> r.ofs[23:16] == $past(reg_wdata))
        else $error("Offset high byte write lost.");

    AST_GAIN_RD: assert property (
        reg_addr == `OGC_ADDR_GAIN_MID |=> reg_rdata == $past(r.gain[15:8]))
        else $error("Gain middle byte read wrong.");

    AST_CANCEL: assert property (
        cal_busy && r.cs_sync |=> !cal_busy ##1 !cal_busy)
        else $error("Calibration survived chip select high.");

    AST_READY: assert property (
        result_valid |-> !data_ready_n)
        else $error("New data without ready low.");

    AST_SHORT: assert property (
        $rose(inputs_shorted) |-> r.kind == ogc_pkg::OGC_K_INT
        && r.st == ogc_pkg::OGC_AVG)
        else $error("Inputs shorted outside internal calibration.");

    AST_AVG_CNT: assert property (
        r.st == ogc_pkg::OGC_AVG && filter_valid && !cancel
        && r.cnt != 5'(AVG_NUM - 1) |=> r.st == ogc_pkg::OGC_AVG)
        else $error("Averaging ended before all conversions.");

    AST_DIV_LEN: assert property (
        $rose(r.st == ogc_pkg::OGC_DIV) && !cs_n
        |-> (r.st == ogc_pkg::OGC_DIV)[*8])
        else $error("Divider ended too early.");

    // The low clip needs its own check: a signed compare that wrapped
    // would still pass the high case and fail only here.
    AST_CLIP_LO: assert property (
        filter_valid && (r.st == ogc_pkg::OGC_IDLE)
        && r.gain == `OGC_GAIN_MAX && filter_data == `OGC_NEG_CLIP
        && r.ofs == `OGC_POS_CLIP
        |=> result_data == `OGC_NEG_CLIP)
        else $error("Overflowing result was not clipped low.");

    AST_UNSHORT: assert property (
        r.st == ogc_pkg::OGC_AVG && filter_valid && !cancel
        && r.cnt == 5'(AVG_NUM - 1) |=> !inputs_shorted)
        else $error("Inputs still shorted after the last sample.");

    AST_CAL_DONE: assert property (
        r.st == ogc_pkg::OGC_FINAL && filter_valid && !cancel
        |=> result_valid && !data_ready_n && !cal_busy)
        else $error("Calibration ended without fresh data.");

    COV_INT: cover property (
        r.kind == ogc_pkg::OGC_K_INT && $fell(cal_busy) && result_valid);
    COV_GAIN: cover property (
        $fell(r.st == ogc_pkg::OGC_DIV) && r.st == ogc_pkg::OGC_FINAL);
    COV_CANCEL: cover property (cal_busy && r.cs_sync);
    // The remaining main scenarios: system offset and a clipped result.
    COV_SYS: cover property (
        r.kind == ogc_pkg::OGC_K_SYS && $fell(cal_busy) && result_valid);
    COV_CLIP: cover property (result_valid && result_data == `OGC_POS_CLIP);

endmodule

`default_nettype wire

// [hw/ogc_map.svh]
// Contract
// - Result is (filter minus offset) times gain over 400000h.
// - Corrected result saturates to 24 bits.
// - Offset bytes live at 07h, 08h, 09h.
// - Offset is two's complement; zero corrects nothing.
// - Gain bytes live at 0Ah, 0Bh, 0Ch.
// - Gain is unsigned; 400000h means unity.
// - Internal offset calibration shorts inputs, averages 16.
// - System offset calibration averages 16 on present inputs.
// - Full-scale calibration maps average to positive full scale.
// - Chip select stays low; raising it cancels calibration.
// - On completion update words, new data, ready low.
// - Calibration length follows data rate and filter.
// - Host may write calibration registers directly.
`ifndef OGC_MAP_SVH
`define OGC_MAP_SVH

// ----------------------------------------------------------------------
// Register addresses
// ----------------------------------------------------------------------
`define OGC_ADDR_OFS_LO   8'h07
`define OGC_ADDR_OFS_MID  8'h08
`define OGC_ADDR_OFS_HI   8'h09
`define OGC_ADDR_GAIN_LO  8'h0A
`define OGC_ADDR_GAIN_MID 8'h0B
`define OGC_ADDR_GAIN_HI  8'h0C

// ----------------------------------------------------------------------
// Reset values and arithmetic constants
// ----------------------------------------------------------------------
`define OGC_OFS_RESET   24'h000000
`define OGC_GAIN_RESET  24'h400000
`define OGC_GAIN_MAX    24'hFFFFFF
`define OGC_FS_CODE     24'h7FFFFF
`define OGC_UNITY_SHIFT 22
`define OGC_SAT_HI      28'sh07FFFFF
`define OGC_SAT_LO      28'shF800000
`define OGC_POS_CLIP    24'h7FFFFF
`define OGC_NEG_CLIP    24'h800000
`define OGC_DIV_LAST    6'd45
`define OGC_AVG_NUM     16

`endif

// [hw/ogc_pkg.sv]
`default_nettype none
package ogc_pkg;

    // ------------------------------------------------------------------
    // Sequencer states and calibration kinds
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        OGC_IDLE,
        OGC_AVG,
        OGC_DIV,
        OGC_FINAL
    } ogc_state_t;

    typedef enum logic [1:0] {
        OGC_K_INT,
        OGC_K_SYS,
        OGC_K_GAIN
    } ogc_kind_t;

    // ------------------------------------------------------------------
    // Complete state of the correction block
    // ------------------------------------------------------------------
    typedef struct packed {
        ogc_state_t         st;
        ogc_kind_t          kind;
        logic               cs_meta;
        logic               cs_sync;
        logic [23:0]        ofs;
        logic [23:0]        gain;
        logic signed [28:0] acc;
        logic [4:0]         cnt;
        logic [24:0]        rem;
        logic [45:0]        quo;
        logic [23:0]        den;
        logic [5:0]         steps;
        logic [23:0]        result;
        logic               result_valid;
        logic               data_ready_n_n;
        logic               shorted;
        logic [7:0]         rdata;
    } ogc_regs_t;

endpackage

`default_nettype wire

// [tb/adc_offset_gain_calibration_bench.sv]
`timescale 1ns/1ps
`default_nettype none
module adc_offset_gain_calibration_bench;
    // ------------------------------------------------------------------
    // Signals and instances
    // ------------------------------------------------------------------
    // Two samples per average keep calibration runs short.
    localparam int AVG = 2;
    localparam logic [23:0] CD [5] = '{24'h123456, 24'h7FFFFF,
        24'h100000, 24'h100000, 24'h800000};
    localparam logic [23:0] CO [5] = '{24'h000000, 24'h800000,
        24'h000000, 24'h000000, 24'h7FFFFF};
    localparam logic [23:0] CG [5] = '{24'h400000, 24'hFFFFFF,
        24'h433333, 24'h3CCCCC, 24'hFFFFFF};
    logic        clock = 1'b0;
    logic        arst_n = 1'b0;
    logic        cs_n = 1'b0;
    logic [2:0]  cmd = 3'h0;
    logic        reg_wr = 1'b0;
    logic [7:0]  reg_addr = 8'h00;
    logic [7:0]  reg_wdata = 8'h00;
    logic [31:0] seed = 32'h00011A31;
    logic [23:0] cur_o;
    logic [23:0] cur_g;
    int          error_cnt = 0;
    int          cmp_count = 0;
    wire logic   conv_start, filter_valid, result_valid, data_ready_n;
    wire logic   inputs_shorted, cal_busy;
    wire logic [23:0] filter_data, result_data;
    wire logic [7:0]  reg_rdata;

    ogc_core #(.AVG_NUM(AVG)) u_ogc_core (
        .clock(clock), .arst_n(arst_n), .cs_n(cs_n),
        .conv_start(conv_start), .filter_valid(filter_valid),
        .filter_data(filter_data), .internal_offset_cal_cmd(cmd[0]),
        .system_offset_cal_cmd(cmd[1]), .full_scale_cal_cmd(cmd[2]),
        .reg_wr(reg_wr), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_rdata(reg_rdata), .result_data(result_data),
        .result_valid(result_valid), .data_ready_n(data_ready_n),
        .inputs_shorted(inputs_shorted), .cal_busy(cal_busy));

    ogc_host_model u_ogc_host_model (
        .clock(clock), .conv_start(conv_start),
        .filter_valid(filter_valid), .filter_data(filter_data));

    // Free-running 250 MHz clock.
    always #2 clock = ~clock;

    // ------------------------------------------------------------------
    // Reference arithmetic and helpers
    // ------------------------------------------------------------------
    function logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction

    // Wide intermediates so that only the final clip limits the result.
    function automatic logic [23:0] corr(input logic [23:0] d, o, g);
        logic signed [25:0] df;
        logic signed [51:0] p;
        df = $signed({d[23], d}) - $signed({o[23], o});
        p = (df * $signed({1'b0, g})) >>> 22;
        if (p > 52'sh7FFFFF) return 24'h7FFFFF;
        if (p < -52'sh800000) return 24'h800000;
        return p[23:0];
    endfunction

    function automatic logic [23:0] gexp(input logic signed [27:0] a);
        logic [47:0] q;
        if (a <= 28'sh0) return 24'hFFFFFF;
        q = (48'h7FFFFF << 22) / 48'(a);
        return (q > 48'hFFFFFF) ? 24'hFFFFFF : q[23:0];
    endfunction

    task automatic check(input logic [47:0] seen, exp);
        cmp_count++;
        if (seen !== exp) begin
            error_cnt++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic wr_word(input logic [7:0] base, input logic [23:0] v);
        for (int i = 0; i < 3; i++) begin
            @(posedge clock) begin
                reg_wr <= 1'b1;
                reg_addr <= base + 8'(i);
                reg_wdata <= v[8*i +: 8];
            end
            @(posedge clock) reg_wr <= 1'b0;
        end
    endtask

    task automatic chk_word(input logic [7:0] base, input logic [23:0] v);
        for (int i = 0; i < 3; i++) begin
            @(posedge clock) reg_addr <= base + 8'(i);
            @(posedge clock);
            #1 check(48'(reg_rdata), 48'(v[8*i +: 8]));
        end
    endtask

    task automatic conv_chk(input logic [23:0] d, exp);
        u_ogc_host_model.convert(d);
        // The result pulse stands one cycle: look just after its edge.
        #1 check(48'(result_valid), 48'h1);
        check(48'(result_data), 48'(exp));
        check(48'(data_ready_n), 48'h0);
    endtask

    task automatic cal_cmd(input int k);
        // This block has no register lock, so every command goes unlocked.
        @(posedge clock) cmd[k] <= 1'b1;
        @(posedge clock) cmd <= 3'h0;
        #1 check(48'(cal_busy), 48'h1);
        check(48'(inputs_shorted), 48'(k == 0));
    endtask

    // Offset calibration: the word becomes the mean of the raw samples.
    task automatic ofs_cal(input int k, input logic [23:0] a, b);
        logic signed [25:0] s;
        logic [23:0]        d;
        cal_cmd(k);
        u_ogc_host_model.convert(a);
        u_ogc_host_model.convert(b);
        s = $signed({a[23], a}) + $signed({b[23], b});
        cur_o = 24'(s >>> 1);
        #1 check(48'(inputs_shorted), 48'h0);
        d = 24'(rnd());
        conv_chk(d, corr(d, cur_o, cur_g));
        check(48'(cal_busy), 48'h0);
        chk_word(8'h07, cur_o);
    endtask

    task automatic tally_and_finish();
        $display("Comparisons %0d, mismatches %0d", cmp_count, error_cnt);
        if (error_cnt == 0 && cmp_count > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    // ------------------------------------------------------------------
    // Main sequence and watchdog
    // ------------------------------------------------------------------
    initial begin
        logic signed [27:0] avg;
        logic [23:0]        d;
        repeat (16) @(posedge clock);
        arst_n <= 1'b1;
        chk_word(8'h07, 24'h000000);
        chk_word(8'h0A, 24'h400000);
        chk_word(8'h0D, 24'h000000);
        // Corner words first, then random words through the same path.
        for (int i = 0; i < 25; i++) begin
            d = (i < 5) ? CD[i] : 24'(rnd());
            cur_o = (i < 5) ? CO[i] : 24'(rnd());
            cur_g = (i < 5) ? CG[i] : 24'(rnd());
            wr_word(8'h07, cur_o);
            wr_word(8'h0A, cur_g);
            conv_chk(d, corr(d, cur_o, cur_g));
        end
        cur_g = 24'h400000;
        wr_word(8'h0A, cur_g);
        // Raising chip select in mid-average abandons the calibration.
        cal_cmd(1);
        @(posedge clock) cs_n <= 1'b1;
        repeat (6) @(posedge clock);
        #1 check(48'(cal_busy), 48'h0);
        chk_word(8'h07, cur_o);
        @(posedge clock) cs_n <= 1'b0;
        repeat (3) @(posedge clock);
        ofs_cal(0, 24'(rnd()), 24'(rnd()));
        ofs_cal(1, 24'hFFFFF0, 24'hFFFFE0);
        // Full-scale calibration after the offset, on corrected data.
        cal_cmd(2);
        // The applied level keeps the corrected signal inside its range.
        u_ogc_host_model.convert(24'h600000);
        u_ogc_host_model.convert(24'h600004);
        avg = (28'sh600000 + 28'sh600004 - 28'sh2 * 28'(signed'(cur_o)))
            >>> 1;
        cur_g = gexp(avg);
        repeat (60) @(posedge clock);
        d = 24'(rnd());
        conv_chk(d, corr(d, cur_o, cur_g));
        check(48'(cal_busy), 48'h0);
        chk_word(8'h0A, cur_g);
        tally_and_finish();
    end

    // Cuts a hang short well beyond the expected run of about seven hundred
    // cycles.
    initial begin
        #100000;
        error_cnt++;
        tally_and_finish();
    end
endmodule
`default_nettype wire

// [tb/ogc_host_model.sv]
`timescale 1ns/1ps
`default_nettype none
module ogc_host_model #(
    parameter int GAP = 3
) (
    input  wire logic        clock,
    output logic             conv_start,
    output logic             filter_valid,
    output logic      [23:0] filter_data
);
    // ------------------------------------------------------------------
    // Conversion source seen by the correction path
    // ------------------------------------------------------------------
    // Idle levels; the data bus never rests on the last valid word.
    initial begin
        conv_start = 1'b0;
        filter_valid = 1'b0;
        filter_data = 24'hA5A5A5;
    end

    // A conversion is announced by its start pulse a few cycles before
    // its data arrives, as a running converter would do.
    task automatic convert(input logic [23:0] d);
        @(posedge clock) conv_start <= 1'b1;
        @(posedge clock) conv_start <= 1'b0;
        repeat (GAP) @(posedge clock) filter_data <= ~filter_data;
        @(posedge clock) begin
            filter_valid <= 1'b1;
            filter_data <= d;
        end
        @(posedge clock) begin
            filter_valid <= 1'b0;
            filter_data <= ~d;
        end
    endtask
endmodule
`default_nettype wire
